// File: design/scan_test_access_and_emulation_pins.sv
`timescale 1ns/100ps
// Function
// - Mode-select and serial data are captured on rising test clock.
// - Selected scan register shifts out on falling test clock.
// - Serial output floats except while a scan is shifting.
// - Test reset high gives the scan system control of the device.
// - Test reset low means functional mode; scan port signals ignored.
// - With test reset high both event pins are bidirectional interrupts.
// - Test reset falling turns event pin one into the float request.
// - Float request low with event pin zero high floats every output including serial output.
module scan_test_access_and_emulation_pins
  import tap_pkg::*;
#(
  parameter int IR_W = IR_WIDTH,
  parameter int DR_W = DR_WIDTH
)(
  // System side
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic dev_evt0_out,
  input  wire logic dev_evt0_oe,
  input  wire logic dev_evt1_out,
  input  wire logic dev_evt1_oe,
  output logic      emu_evt0_irq,
  output logic      emu_evt1_irq,
  output logic      scan_control,
  output logic      outputs_float,
  output logic [DR_W-1:0] user_dr,
  // Scan port
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trst_n,
  output logic      tdo_o,
  output logic      tdo_oe,
  // Event pins
  input  wire logic emulator_event_pin_zero_i,
  output logic      emulator_event_pin_zero_o,
  output logic      emulator_event_pin_zero_oe,
  input  wire logic emulator_event_pin_one_or_float_i,
  output logic      emulator_event_pin_one_or_float_o,
  output logic      emulator_event_pin_one_or_float_oe
);

  tap_state_if st ();

  tap_fsm u_fsm (
    .tck    (tck),
    .trst_n (trst_n),
    .tms    (tms),
    .st     (st.ctrl)
  );

  // ---------------------------------------------------------------
  // Scan registers, test clock domain
  // ---------------------------------------------------------------
  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  logic [DR_W-1:0] dr_sh_q;
  logic [DR_W-1:0] dr_upd_q;
  logic            byp_q;
  logic            tdo_q;
  logic            tdo_en_q;
  logic            upd_tgl_q;
  logic            float_mode_q;

  wire sel_bypass = (ir_q == IR_BYPASS[IR_W-1:0]);
  wire sel_user   = (ir_q == IR_USER[IR_W-1:0]);
  wire scan_out   = (st.state == ST_SHIFT_IR) ? ir_sh_q[0]
                  : (sel_bypass ? byp_q : dr_sh_q[0]);

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh_q  <= '0;
      ir_q     <= IR_BYPASS[IR_W-1:0];
      dr_sh_q  <= '0;
      dr_upd_q <= '0;
      byp_q    <= 1'b0;
      upd_tgl_q <= 1'b0;
    end else begin
      case (st.state)
        ST_RESET:    ir_q    <= IR_BYPASS[IR_W-1:0];
        ST_CAP_IR:   ir_sh_q <= IR_CAPTURE[IR_W-1:0];
        ST_SHIFT_IR: ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
        ST_UPD_IR:   ir_q    <= ir_sh_q;
        ST_CAP_DR: begin
          dr_sh_q <= DR_CAPTURE[DR_W-1:0];
          byp_q   <= 1'b0;
        end
        ST_SHIFT_DR: begin
          dr_sh_q <= {tdi, dr_sh_q[DR_W-1:1]};
          byp_q   <= tdi;
        end
        ST_UPD_DR: begin
          if (sel_user) begin
            dr_upd_q  <= dr_sh_q;
            upd_tgl_q <= ~upd_tgl_q;
          end
        end
        default:     ;
      endcase
    end
  end

  // Data and enable move together on the falling edge
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tdo_q    <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      tdo_q    <= scan_out;
      tdo_en_q <= st.shifting;
    end
  end

  // ---------------------------------------------------------------
  // Crossings into sys_clk
  // ---------------------------------------------------------------
  // Data word crosses by toggle; it is stable long before the next update
  logic [3:0]      s1_q;
  logic [3:0]      s2_q;
  logic [DR_W-1:0] user_dr_q;
  logic            ctl_prev_q;
  logic            tgl_prev_q;
  wire [3:0] raw = {trst_n, emulator_event_pin_zero_i, emulator_event_pin_one_or_float_i,
                    upd_tgl_q};

  wire ctl       = s2_q[3];
  wire ev0_sync  = s2_q[2];
  wire ev1_sync  = s2_q[1];
  wire upd_seen  = s2_q[0] ^ tgl_prev_q;
  wire arm_next  = !ctl && (ctl_prev_q || float_mode_q);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_q       <= '0;
      s2_q       <= '0;
      user_dr_q  <= '0;
      ctl_prev_q <= 1'b0;
      tgl_prev_q <= 1'b0;
    end else begin
      s1_q       <= raw;
      s2_q       <= s1_q;
      ctl_prev_q <= s2_q[3];
      tgl_prev_q <= s2_q[0];
      if (upd_seen) user_dr_q <= dr_upd_q;
    end
  end

  // ---------------------------------------------------------------
  // Float request latch: armed on test reset falling edge
  // ---------------------------------------------------------------
  // Held while test reset stays low, dropped once scan control returns
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      float_mode_q <= 1'b0;
    end else begin
      float_mode_q <= arm_next;
    end
  end

  // Float only with event pin zero high and request low
  wire float_now = float_mode_q && ev0_sync && !ev1_sync;

  assign scan_control  = ctl;
  assign outputs_float = float_now;
  assign emu_evt0_irq  = ctl && ev0_sync;
  assign emu_evt1_irq  = ctl && ev1_sync;
  assign user_dr       = user_dr_q;

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  // Float follows the synchronised pins, so drivers let go a few clocks late
  assign tdo_o  = tdo_q;
  assign tdo_oe = tdo_en_q && !float_now;

  assign emulator_event_pin_zero_o           = dev_evt0_out;
  assign emulator_event_pin_zero_oe          = ctl && dev_evt0_oe && !float_now;
  assign emulator_event_pin_one_or_float_o   = dev_evt1_out;
  assign emulator_event_pin_one_or_float_oe  = ctl && dev_evt1_oe && !float_mode_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_tdo_float;
    @(posedge tck) disable iff (!trst_n)
      !st.shifting |-> !tdo_oe;
  endproperty
  a_tdo_float: assert property (p_tdo_float)
    else $error("serial output enabled outside shift");

  property p_tdo_en;
    @(negedge tck) disable iff (!trst_n)
      1'b1 |=> (tdo_en_q == $past(st.shifting));
  endproperty
  a_tdo_en: assert property (p_tdo_en)
    else $error("output enable not tied to shift state");

  property p_tdo_data;
    @(negedge tck) disable iff (!trst_n)
      1'b1 |=> (tdo_q == $past(scan_out));
  endproperty
  a_tdo_data: assert property (p_tdo_data)
    else $error("serial output not the shifted bit");

  property p_ir_shift;
    @(posedge tck) disable iff (!trst_n)
      (st.state == ST_SHIFT_IR) |=> (ir_sh_q[IR_W-1] == $past(tdi));
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("serial input not captured");

  property p_float_oe;
    @(posedge sys_clk) disable iff (reset)
      float_now |-> !emulator_event_pin_zero_oe && !emulator_event_pin_one_or_float_oe;
  endproperty
  a_float_oe: assert property (p_float_oe)
    else $error("driver active during float");

  property p_func_quiet;
    @(posedge sys_clk) disable iff (reset)
      (emu_evt0_irq == (ctl && $past(emulator_event_pin_zero_i, 2))) &&
      (emu_evt1_irq == (ctl && $past(emulator_event_pin_one_or_float_i, 2)));
  endproperty
  a_func_quiet: assert property (p_func_quiet)
    else $error("event line not gated by scan control");

  property p_arm;
    @(posedge sys_clk) disable iff (reset)
      ($fell(ctl)) |=> float_mode_q;
  endproperty
  a_arm: assert property (p_arm)
    else $error("float request not armed");

  property p_ctl;
    @(posedge sys_clk) disable iff (reset)
      ctl |=> !float_mode_q;
  endproperty
  a_ctl: assert property (p_ctl)
    else $error("float armed under scan control");

  c_shift_dr: cover property (@(posedge tck) st.state == ST_SHIFT_DR);
  c_upd_ir:   cover property (@(posedge tck) st.state == ST_UPD_IR);
  c_float:    cover property (@(posedge sys_clk) float_now);

endmodule : scan_test_access_and_emulation_pins

// File: design/tap_pkg.sv
package tap_pkg;

  // ---------------------------------------------------------------
  // Controller states, one-hot
  // ---------------------------------------------------------------
  localparam int TAP_STATES = 16;

  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_e;

  // ---------------------------------------------------------------
  // Register layout
  // ---------------------------------------------------------------
  localparam int          IR_WIDTH    = 4;
  localparam int          DR_WIDTH    = 32;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam logic [3:0]  IR_USER     = 4'h2;
  localparam logic [31:0] DR_CAPTURE  = 32'h00000001;

endpackage : tap_pkg

// File: design/tap_state_if.sv
`timescale 1ns/100ps
interface tap_state_if;
  import tap_pkg::*;
  tap_state_e state;
  logic       shifting;
  modport ctrl (output state, output shifting);
  modport user (input state, input shifting);
endinterface : tap_state_if

// File: design/tap_fsm.sv
`timescale 1ns/100ps
module tap_fsm
  import tap_pkg::*;
(
  // Test clock and reset
  input  wire logic tck,
  input  wire logic trst_n,
  // Mode select
  input  wire logic tms,
  // State out
  tap_state_if.ctrl st
);

  tap_state_e state_q;
  tap_state_e state_d;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    case (state_q)
      ST_RESET:    state_d = tms ? ST_RESET    : ST_IDLE;
      ST_IDLE:     state_d = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   state_d = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   state_d = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   state_d = tms ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   state_d = tms ? ST_SEL_DR   : ST_IDLE;
      default:     state_d = ST_RESET;
    endcase
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_q <= ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign st.state    = state_q;
  assign st.shifting = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_five_ones_reset;
    @(posedge tck) disable iff (!trst_n)
      tms [*5] |=> (state_q == ST_RESET);
  endproperty
  a_five_ones_reset: assert property (p_five_ones_reset)
    else $error("five tms ones did not reach reset");

  property p_shift_hold;
    @(posedge tck) disable iff (!trst_n)
      (state_q == ST_SHIFT_DR && !tms) |=> (state_q == ST_SHIFT_DR);
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("shift state left with tms low");

  property p_onehot;
    @(posedge tck) disable iff (!trst_n) $onehot(state_q);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("state not one-hot");

endmodule : tap_fsm

// File: dv/scan_ctrl_model.sv
`timescale 1ns/100ps
module scan_ctrl_model (
  // Scan port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  // Event pin drive
  output logic      p0_o,
  output logic      p0_oe,
  output logic      p1_o,
  output logic      p1_oe
);
  logic oe_s;
  logic oe_all;
  initial begin
    {tck, tms, tdi, trst_n} = 4'h6;
    {p0_o, p0_oe, p1_o, p1_oe} = 4'h0;
    oe_all = 1'b1;
  end
  // -------------------------------------------------------------
  // Link clock only runs inside these tasks
  // -------------------------------------------------------------
  task automatic bit_t(input logic t, input logic d, output logic o);
    tms = t;
    tdi = d;
    #80;
    o = tdo;
    oe_s = tdo_oe;
    tck = 1'b1;
    #80;
    tck = 1'b0;
  endtask : bit_t
  task automatic nav(input logic [7:0] seq, input int n);
    logic o;
    for (int i = 0; i < n; i++) bit_t(seq[i], 1'b0, o);
  endtask : nav
  // Lsb first, then update and idle
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      bit_t(i == n - 1, din[i], o);
      dout[i] = o;
      oe_all = oe_all & oe_s;
    end
    nav(8'h01, 2);
  endtask : shift
  task automatic set_trst(input logic v);
    trst_n <= v;
  endtask : set_trst
  task automatic set_pins(input logic [3:0] v);
    {p0_o, p0_oe, p1_o, p1_oe} <= v;
  endtask : set_pins
  task automatic enter_float();
    {p0_o, p0_oe, p1_o, p1_oe} <= 4'hf;
    #160 trst_n <= 1'b0;
    #160 p1_o <= 1'b0;
  endtask : enter_float
endmodule : scan_ctrl_model

// File: dv/scan_test_access_and_emulation_pins_tb_top.sv
`timescale 1ns/100ps
module scan_test_access_and_emulation_pins_tb_top;
  import tap_pkg::*;
  logic                sys_clk, reset, tck, tms, tdi, trst_n, tdo_o, tdo_oe, tdo_w;
  logic                dev_evt0_out, dev_evt0_oe, dev_evt1_out, dev_evt1_oe;
  logic                emu_evt0_irq, emu_evt1_irq, scan_control, outputs_float;
  logic [DR_WIDTH-1:0] user_dr;
  logic                p0_i, p0_o, p0_oe, p1_i, p1_o, p1_oe;
  logic                m0_o, m0_oe, m1_o, m1_oe;
  logic [31:0]         got, val;
  logic [3:0]          r;
  int                  miscompares = 0;
  int                  cmp_count = 0;
  // Released serial output shows the inverse, so a stale value never matches; released event pins pull high
  assign tdo_w = tdo_oe ? tdo_o : ~tdo_o;
  assign p0_i  = p0_oe ? p0_o : (m0_oe ? m0_o : 1'b1);
  assign p1_i  = p1_oe ? p1_o : (m1_oe ? m1_o : 1'b1);
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  scan_test_access_and_emulation_pins DUT (
    .sys_clk(sys_clk), .reset(reset),
    .dev_evt0_out(dev_evt0_out), .dev_evt0_oe(dev_evt0_oe),
    .dev_evt1_out(dev_evt1_out), .dev_evt1_oe(dev_evt1_oe),
    .emu_evt0_irq(emu_evt0_irq), .emu_evt1_irq(emu_evt1_irq),
    .scan_control(scan_control), .outputs_float(outputs_float), .user_dr(user_dr),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
    .emulator_event_pin_zero_i(p0_i), .emulator_event_pin_zero_o(p0_o),
    .emulator_event_pin_zero_oe(p0_oe), .emulator_event_pin_one_or_float_i(p1_i),
    .emulator_event_pin_one_or_float_o(p1_o), .emulator_event_pin_one_or_float_oe(p1_oe)
  );
  scan_ctrl_model m (
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_w), .tdo_oe(tdo_oe),
    .p0_o(m0_o), .p0_oe(m0_oe), .p1_o(m1_o), .p1_oe(m1_oe)
  );
  task automatic chk_bit(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: bit %b, want %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: word %h, want %h", $time, g, e);
    end
  endtask : chk_word
  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // Two-flop synchronizers need a few system cycles
  task automatic settle();
    repeat (8) @(posedge sys_clk);
  endtask : settle
  initial begin : watchdog
    #200000;
    miscompares++;
    $display("unexpected at %0t: run hung", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(32'hc9597d4e));
    {reset, dev_evt0_out, dev_evt0_oe, dev_evt1_out, dev_evt1_oe} = 5'h10;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    m.nav(8'h03, 4);
    settle();
    chk_bit(scan_control, 1'b0);
    chk_bit(tdo_oe, 1'b0);
    m.set_trst(1'b1);
    #320;
    settle();
    chk_bit(scan_control, 1'b1);
    m.nav(8'h06, 5);
    m.shift(IR_WIDTH, {28'h0, IR_USER}, got);
    chk_word(got, {28'h0, IR_CAPTURE});
    chk_bit(m.oe_all, 1'b1);
    chk_bit(tdo_oe, 1'b0);
    val = $urandom();
    m.nav(8'h01, 3);
    m.shift(DR_WIDTH, val, got);
    chk_word(got, DR_CAPTURE);
    for (int i = 0; i < 100 && user_dr !== val; i++) @(posedge sys_clk);
    chk_word(user_dr, val);
    // Five ones reset the controller, instruction back to bypass
    m.nav(8'h1f, 6);
    m.nav(8'h01, 3);
    m.shift(2, 32'h1, got);
    chk_word(got, 32'h2);
    repeat (4) begin
      r = 4'($urandom());
      m.set_pins({r[0], 1'b1, r[1], 1'b1});
      settle();
      chk_bit(emu_evt0_irq, r[0]);
      chk_bit(emu_evt1_irq, r[1]);
      m.set_pins(4'h0);
      @(posedge sys_clk);
      {dev_evt0_out, dev_evt0_oe, dev_evt1_out, dev_evt1_oe} <= {r[2], 1'b1, r[3], 1'b1};
      settle();
      chk_word({p0_o, p0_oe, p1_o, p1_oe}, {28'h0, r[2], 1'b1, r[3], 1'b1});
      {dev_evt0_oe, dev_evt1_oe} <= 2'h0;
    end
    m.enter_float();
    settle();
    chk_bit(scan_control, 1'b0);
    chk_bit(outputs_float, 1'b1);
    chk_bit(tdo_oe, 1'b0);
    chk_bit(p1_oe, 1'b0);
    m.set_pins(4'hf);
    settle();
    chk_bit(outputs_float, 1'b0);
    print_verdict();
  end
endmodule : scan_test_access_and_emulation_pins_tb_top
